//--- dv/scrb_master.sv
// Bus master model issuing single transfers to the register bank
`timescale 1ns/1ps
module scrb_master (
  input wire logic clk_i,
  input wire logic hreadyout_i,
  input wire logic [31:0] hrdata_i,
  output scrb_pkg::scrb_ahb_req_t ahb_o,
  output logic [31:0] hwdata_o
);
  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  initial begin
    ahb_o = '0;
    ahb_o.ready = 1'b1;
    hwdata_o = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Address phase, then data phase; released data is inverted
  // ----------------------------------------------------------------
  // transfers of the size passed in size
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [2:0] size,
    input logic [31:0] wdata, output logic [31:0] rdata, output logic ok);
    int n;
    @(posedge clk_i);
    #1;
    ahb_o.sel = 1'b1;
    ahb_o.trans = 2'h2;
    ahb_o.write = wr;
    ahb_o.addr = addr;
    ahb_o.size = size;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_i !== 1'b1 && n < 16);
    #1;
    ahb_o.sel = 1'b0;
    ahb_o.trans = 2'h0;
    ahb_o.addr = ~addr;
    hwdata_o = wr ? wdata : ~hwdata_o;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_i !== 1'b1 && n < 32);
    rdata = hrdata_i;
    ok = n < 32;
    #1;
    hwdata_o = ~hwdata_o;
  endtask
endmodule // scrb_master

//--- dv/system_config_register_bank_tb_top.sv
// Self-checking testbench for the system register bank
`timescale 1ns/1ps
module system_config_register_bank_tb_top;
  // Arbitrary value
  localparam logic [31:0] VER = 32'h0000_1234;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic system_reset_low = 1'b1;
  logic clock_ctrl_reset_low = 1'b1;
  scrb_pkg::scrb_flash_t flash;
  scrb_pkg::scrb_evt_t evt;
  scrb_pkg::scrb_ahb_req_t ahb;
  logic [scrb_pkg::NRO-1:0][31:0] ro_status;
  logic [scrb_pkg::NCFG-1:0][31:0] cfg;
  logic [scrb_pkg::NHID-1:0][31:0] hidden;
  logic [1:0][31:0] fprot;
  logic [1:0][3:0] waitc;
  logic [31:0] hwdata, hrdata, rcause, flush;
  logic hreadyout, hresp, pipe;
  int err_total = 0;
  int checks = 0;

  always #12.5 clk_i = ~clk_i;

  scrb_master mst (.clk_i(clk_i), .hreadyout_i(hreadyout), .hrdata_i(hrdata), .ahb_o(ahb),
    .hwdata_o(hwdata));
  scrb_bank #(.RCC_RESET(scrb_pkg::RCC_RST_DEF), .SILICON_VERSION(VER)) uut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .system_reset_low_i(system_reset_low),
    .clock_ctrl_reset_low_i(clock_ctrl_reset_low), .ahb_i(ahb), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .flash_i(flash),
    .evt_i(evt), .ro_status_i(ro_status), .cfg_o(cfg), .reset_cause_o(rcause),
    .hidden_o(hidden), .fabric_protect_o(fprot), .sram_wait_cycles_o(waitc),
    .sram_pipeline_en_o(pipe), .flush_o(flush));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d comparisons, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus access
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [31:0] a, input logic [2:0] sz,
    input logic [31:0] wd, output logic [31:0] rd);
    logic ok;
    mst.xfer(wr, a, sz, wd, rd, ok);
    if (ok !== 1'b1) begin
      err_total++;
      $display("ERROR handshake expected ready seen stuck");
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, scrb_pkg::BASE_ADDR | {20'h0_0000, ofs}, scrb_pkg::SIZE_WORD, d, r);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] ofs, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, scrb_pkg::BASE_ADDR | {20'h0_0000, ofs}, scrb_pkg::SIZE_WORD, 32'h0, r);
    check(what, r, exp);
  endtask

  task automatic pulse(input logic [1:0] s, input logic [1:0] d, input logic [31:0] ie,
    input logic [31:0] ee);
    @(posedge clk_i);
    #1;
    evt.sec = s;
    evt.ded = d;
    evt.int_ev = ie;
    evt.ext_ev = ee;
    @(posedge clk_i);
    #1;
    evt.sec = 2'h0;
    evt.ded = 2'h0;
    evt.int_ev = 32'h0;
    evt.ext_ev = 32'h0;
  endtask

  task automatic hold_low(ref logic line);
    @(posedge clk_i);
    #1;
    line = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    line = 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  // Expected write mask from the lock settings below
  function automatic logic [31:0] mask_of(input int i);
    if (i == scrb_pkg::IDX_SRST) return flash.lock[i];
    if (i == scrb_pkg::IDX_FACC1) return 32'h0F0F_0F0F;
    if (i == scrb_pkg::IDX_FACC2) return 32'hF0F0_F0F0;
    return {32{flash.lock[i][0]}};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [3:0] e1, e0;
    flash = '0;
    evt = '0;
    ro_status = '0;
    for (int i = 0; i < scrb_pkg::NCFG; i++) begin
      flash.init[i] = 32'h5A5A_0000 + 32'(i) * 32'h0000_0111;
      flash.lock[i] = 32'hFFFF_FFFF;
    end
    flash.init[0] = 32'h0000_0029;
    flash.lock[1] = 32'h0000_0000;
    flash.lock[11] = 32'h0000_FFFF;
    flash.lock[20] = 32'h0000_0055;
    flash.lock[21] = 32'h0000_00AA;
    flash.prot = {32'h2000_0000, 32'h0001_0000};
    for (int i = 0; i < scrb_pkg::NHID; i++) flash.hid[i] = 32'hB0B0_0000 + 32'(i);
    evt.adr = {32'h2000_5678, 32'h2000_1234};
    repeat (8) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);

    for (int i = 0; i < scrb_pkg::NCFG; i++) begin
      rd_chk("cfg load", scrb_pkg::CFG_OFS[i], flash.init[i]);
    end
    check("wait0", {28'h0, waitc[0]}, 32'h1);
    check("wait1", {28'h0, waitc[1]}, 32'h5);
    rd_chk("reset cause", scrb_pkg::OFS_RCC, scrb_pkg::RCC_RST_DEF);
    rd_chk("prot size", scrb_pkg::OFS_PSIZE, flash.prot[0]);
    rd_chk("prot base", scrb_pkg::OFS_PBASE, flash.prot[1]);
    check("cause out", rcause, scrb_pkg::RCC_RST_DEF);
    check("prot out", fprot[1], flash.prot[1]);
    rd_chk("version", scrb_pkg::OFS_VER, VER);
    for (int i = 0; i < scrb_pkg::NHID; i++) begin
      rd_chk("hidden read", scrb_pkg::HID_OFS[i], 32'h0);
      check("hidden out", hidden[i], flash.hid[i]);
    end
    $display("test reset_load done");

    for (int i = 0; i < scrb_pkg::NCFG; i++) begin
      wr(scrb_pkg::CFG_OFS[i], ~flash.init[i]);
      rd_chk("cfg lock", scrb_pkg::CFG_OFS[i], flash.init[i] ^ mask_of(i));
      check("cfg out", cfg[i], flash.init[i] ^ mask_of(i));
    end
    $display("test locks done");

    for (int c = 0; c < 8; c++) begin
      wr(12'h004, {26'h0, 3'(c), 3'(7 - c)});
      wr(12'h080, {31'h0, 1'(c)});
      e1 = (c == 0) ? 4'h8 : 4'(c);
      e0 = (c == 7) ? 4'h8 : 4'(7 - c);
      check("wait1 code", {28'h0, waitc[1]}, {28'h0, e1});
      check("wait0 code", {28'h0, waitc[0]}, {28'h0, e0});
      check("pipeline", {31'h0, pipe}, {31'h0, 1'(c)});
    end
    $display("test latency done");

    bus(1'b1, scrb_pkg::BASE_ADDR | 32'h4, 3'h1, 32'h0000_003F, r);
    bus(1'b1, 32'h4003_9004, scrb_pkg::SIZE_WORD, 32'h0000_0009, r);
    rd_chk("refused writes", 12'h004, 32'h0000_0038);
    bus(1'b0, 32'h4003_9004, scrb_pkg::SIZE_WORD, 32'h0, r);
    check("outside read", r, 32'h0);
    check("no error", {31'h0, hresp}, 32'h0);
    wr(12'h008, 32'hFFFF_FFFF);
    rd_chk("reserved", 12'h008, 32'h0);
    wr(12'h128, 32'hFFFF_FFFF);
    check("hidden write", hidden[0], flash.hid[0]);
    wr(scrb_pkg::OFS_PSIZE, 32'hFFFF_FFFF);
    rd_chk("prot ro", scrb_pkg::OFS_PSIZE, flash.prot[0]);
    rd_chk("clear wo", scrb_pkg::OFS_CLR, 32'h0);
    $display("test refusals done");

    wr(12'h078, 32'h0000_000F);
    pulse(2'h3, 2'h0, 32'h0000_0020, 32'h0000_0004);
    rd_chk("ecc status", 12'h190, 32'h0000_0005);
    rd_chk("count0", scrb_pkg::OFS_CNT0, 32'h0000_0001);
    rd_chk("addr0", scrb_pkg::OFS_ADR0, 32'h2000_1234);
    rd_chk("addr1", scrb_pkg::OFS_ADR1, 32'h2000_5678);
    rd_chk("int status", 12'h194, 32'h0000_0020);
    rd_chk("ext status", 12'h198, 32'h0000_0004);
    wr(12'h190, 32'h0000_0001);
    wr(12'h194, 32'h0000_0020);
    rd_chk("one cleared", 12'h190, 32'h0000_0004);
    rd_chk("int cleared", 12'h194, 32'h0);
    wr(12'h198, 32'h0000_0004);
    rd_chk("ext cleared", 12'h198, 32'h0);
    wr(12'h078, 32'h0);
    pulse(2'h0, 2'h2, 32'h0, 32'h0);
    rd_chk("gated status", 12'h190, 32'h0000_0004);
    rd_chk("count1", scrb_pkg::OFS_CNT1, 32'h0001_0001);
    wr(scrb_pkg::OFS_CLR, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    rd_chk("cleared0", scrb_pkg::OFS_CNT0, 32'h0);
    rd_chk("cleared1", scrb_pkg::OFS_CNT1, 32'h0);
    wr(scrb_pkg::OFS_FLUSH, 32'h0000_0003);
    check("flush pulse", flush, 32'h0000_0003);
    @(posedge clk_i);
    #1;
    check("flush end", flush, 32'h0);
    $display("test events done");

    wr(scrb_pkg::OFS_RCC, 32'h0000_00FF);
    rd_chk("cause rw", scrb_pkg::OFS_RCC, 32'h0000_00FF);
    hold_low(system_reset_low);
    rd_chk("lat sys", 12'h004, flash.init[0]);
    rd_chk("ddr keeps", 12'h060, ~flash.init[13]);
    rd_chk("pll keeps", 12'h090, ~flash.init[18]);
    rd_chk("status sys", 12'h190, 32'h0);
    rd_chk("cause sys", scrb_pkg::OFS_RCC, scrb_pkg::RCC_RST_DEF);
    wr(12'h004, 32'h0000_0012);
    hold_low(clock_ctrl_reset_low);
    rd_chk("pll cc", 12'h090, flash.init[18]);
    rd_chk("fabric_clock_controller cc", 12'h098, flash.init[20]);
    rd_chk("lat keeps", 12'h004, 32'h0000_0012);
    rd_chk("ddr keeps2", 12'h060, ~flash.init[13]);
    hold_low(rst_n_i);
    rd_chk("ddr por", 12'h060, flash.init[13]);
    $display("test resets done");
    end_of_test();
  end
endmodule // system_config_register_bank_tb_top

//--- rtl/scrb_bank.sv
// System configuration and status register bank on the bus matrix
`timescale 1ns/1ps

// Functional notes
// - Lock bit 0 blocks writes; 1 allows.
// - Decode offsets from fixed base address.
// - Latency register flash-loaded, locked whole, system reset.
// - DDR, clock mux, calibration: power-on only.
// - PLL and clock controller: clock-controller reset.
// - Soft-reset register locks per bit.
// - Clock controller registers lock per field.
// - Writing one clears all SRAM error counters.
// - Three status registers sticky, write-one clear.
// - Per-SRAM single/double error counts, read-only.
// - Per-SRAM error address captured, read-only.
// - Master security registers flash-loaded, bus-hidden.
// - Latency fields [5:3] SRAM1, [2:0] SRAM0.
// - Latency code 0 means eight cycles.
// - Reset cause register plain read-write, loads RCC_RESET on system reset.
// - Enable register gates error status reporting.
// - Pipeline register selects SRAM read stage.
// - Code-shadow status hidden, power-on reset only.
// - Fabric protect size/base read-only, flash-loaded.
// - Flash load at power-up and system reset.
// - Sticky bits set on input, clear individually.
// - Pulse registers write-only, one triggers action.
// - Hidden registers refuse bus reads and writes.
module scrb_bank #(
  parameter logic [31:0] RCC_RESET = scrb_pkg::RCC_RST_DEF,
  // Arbitrary value
  parameter logic [31:0] SILICON_VERSION = 32'h0000_0A5A
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic system_reset_low_i,
  input wire logic clock_ctrl_reset_low_i,
  input wire scrb_pkg::scrb_ahb_req_t ahb_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire scrb_pkg::scrb_flash_t flash_i,
  input wire scrb_pkg::scrb_evt_t evt_i,
  input wire logic [scrb_pkg::NRO-1:0][31:0] ro_status_i,
  output logic [scrb_pkg::NCFG-1:0][31:0] cfg_o,
  output logic [31:0] reset_cause_o,
  output logic [scrb_pkg::NHID-1:0][31:0] hidden_o,
  output logic [1:0][31:0] fabric_protect_o,
  output logic [1:0][3:0] sram_wait_cycles_o,
  output logic sram_pipeline_en_o,
  output logic [31:0] flush_o
);

  localparam scrb_pkg::scrb_state_t ST_RST = '{por_pend: 1'b1, default: '0};

  scrb_pkg::scrb_state_t q;
  scrb_pkg::scrb_state_t n;
  logic sys_rst;
  logic cc_rst;
  logic acc;
  logic hit;
  logic [11:0] a;
  logic [31:0] rd;
  logic [31:0] m;
  logic [3:0] ecc_ev;
  logic [scrb_pkg::NSTS-1:0][31:0] clr;
  logic [scrb_pkg::NSTS-1:0][31:0] set;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lock_mask(input int idx, input logic [31:0] lk);
    logic [31:0] mk;
    mk = {32{lk[0]}};
    if (idx == scrb_pkg::IDX_SRST) begin
      mk = lk;
    end else if (idx == scrb_pkg::IDX_FACC1 || idx == scrb_pkg::IDX_FACC2) begin
      for (int f = 0; f < 32 / scrb_pkg::FIELD_W; f++) begin
        mk[f*scrb_pkg::FIELD_W +: scrb_pkg::FIELD_W] = {scrb_pkg::FIELD_W{lk[f]}};
      end
    end
    return mk;
  endfunction

  // code zero stands for eight cycles
  function automatic logic [3:0] lat_cycles(input logic [2:0] code);
    return (code == 3'h0) ? scrb_pkg::LAT_ZERO_CYC : {1'b0, code};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    n.clr_cnt = 1'b0;
    n.flush = '0;
    n.sys_sync = {q.sys_sync[0], system_reset_low_i};
    n.cc_sync = {q.cc_sync[0], clock_ctrl_reset_low_i};
    sys_rst = !q.sys_sync[1];
    cc_rst = !q.cc_sync[1];
    clr = '0;
    m = '0;

    // window match against the fixed base
    hit = ahb_i.addr[31:scrb_pkg::WIN_LSB] == scrb_pkg::BASE_ADDR[31:scrb_pkg::WIN_LSB];
    acc = ahb_i.sel && ahb_i.trans[1] && ahb_i.ready;
    a = ahb_i.addr[11:0];
    n.wr_pend = acc && ahb_i.write && hit && (ahb_i.size == scrb_pkg::SIZE_WORD);
    n.wr_ofs = a;

    rd = '0;
    for (int i = 0; i < scrb_pkg::NCFG; i++) begin
      if (a == scrb_pkg::CFG_OFS[i]) begin
        rd = q.cfg[i];
      end
    end
    for (int i = 0; i < scrb_pkg::NRO; i++) begin
      if (a == scrb_pkg::RO_OFS[i]) begin
        rd = ro_status_i[i];
      end
    end
    for (int i = 0; i < scrb_pkg::NSTS; i++) begin
      if (a == scrb_pkg::STS_OFS[i]) begin
        rd = q.sts[i];
      end
    end
    case (a)
      scrb_pkg::OFS_RCC: rd = q.rst_cause;
      scrb_pkg::OFS_CNT0: rd = {q.ded_cnt[0], q.sec_cnt[0]};
      scrb_pkg::OFS_CNT1: rd = {q.ded_cnt[1], q.sec_cnt[1]};
      scrb_pkg::OFS_ADR0: rd = q.err_adr[0];
      scrb_pkg::OFS_ADR1: rd = q.err_adr[1];
      scrb_pkg::OFS_VER: rd = SILICON_VERSION;
      scrb_pkg::OFS_PSIZE: rd = q.prot[0];
      scrb_pkg::OFS_PBASE: rd = q.prot[1];
      default: ;
    endcase
    if (acc) begin
      n.rdata = (hit && !ahb_i.write) ? rd : '0;
    end

    // Data phase write
    if (q.wr_pend) begin
      for (int i = 0; i < scrb_pkg::NCFG; i++) begin
        if (q.wr_ofs == scrb_pkg::CFG_OFS[i]) begin
          m = lock_mask(i, flash_i.lock[i]);
          n.cfg[i] = (q.cfg[i] & ~m) | (hwdata_i & m);
        end
      end
      for (int i = 0; i < scrb_pkg::NSTS; i++) begin
        if (q.wr_ofs == scrb_pkg::STS_OFS[i]) begin
          clr[i] = hwdata_i;
        end
      end
      case (q.wr_ofs)
        scrb_pkg::OFS_RCC: n.rst_cause = hwdata_i;
        scrb_pkg::OFS_CLR: n.clr_cnt = hwdata_i[0];
        scrb_pkg::OFS_FLUSH: n.flush = hwdata_i;
        default: ;
      endcase
    end

    ecc_ev = {evt_i.ded[1], evt_i.sec[1], evt_i.ded[0], evt_i.sec[0]}
      & q.cfg[scrb_pkg::IDX_ECC_EN][3:0];
    set[0] = {28'h0, ecc_ev};
    set[1] = evt_i.int_ev;
    set[2] = evt_i.ext_ev;
    for (int i = 0; i < scrb_pkg::NSTS; i++) begin
      n.sts[i] = (q.sts[i] & ~clr[i]) | set[i];
    end

    for (int s = 0; s < 2; s++) begin
      if (q.clr_cnt) begin
        n.sec_cnt[s] = '0;
        n.ded_cnt[s] = '0;
      end
      n.sec_cnt[s] = n.sec_cnt[s] + {15'h0, evt_i.sec[s]};
      n.ded_cnt[s] = n.ded_cnt[s] + {15'h0, evt_i.ded[s]};
      if (evt_i.sec[s] || evt_i.ded[s]) begin
        n.err_adr[s] = evt_i.adr[s];
      end
    end

    if (sys_rst || q.por_pend) begin
      for (int i = 0; i < scrb_pkg::NCFG; i++) begin
        if (!scrb_pkg::CFG_POR[i] && !scrb_pkg::CFG_CC[i]) begin
          n.cfg[i] = flash_i.init[i];
        end
      end
      // security and region masks from flash
      for (int i = 0; i < scrb_pkg::HID_POR_IDX; i++) begin
        n.hid[i] = flash_i.hid[i];
      end
      n.prot = flash_i.prot;
      n.rst_cause = RCC_RESET;
      n.sec_cnt = '0;
      n.ded_cnt = '0;
      n.err_adr = '0;
      n.sts = '0;
      n.clr_cnt = 1'b0;
    end
    if (cc_rst || q.por_pend) begin
      for (int i = 0; i < scrb_pkg::NCFG; i++) begin
        if (scrb_pkg::CFG_CC[i]) begin
          n.cfg[i] = flash_i.init[i];
        end
      end
    end
    if (q.por_pend) begin
      for (int i = 0; i < scrb_pkg::NCFG; i++) begin
        if (scrb_pkg::CFG_POR[i]) begin
          n.cfg[i] = flash_i.init[i];
        end
      end
      n.hid[scrb_pkg::HID_POR_IDX] = flash_i.hid[scrb_pkg::HID_POR_IDX];
      n.por_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata_o = q.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign cfg_o = q.cfg;
  assign reset_cause_o = q.rst_cause;
  // hidden values go to the subsystem only
  assign hidden_o = q.hid;
  assign fabric_protect_o = q.prot;
  // SRAM1 in [5:3], SRAM0 in [2:0]
  assign sram_wait_cycles_o[0] = lat_cycles(q.cfg[scrb_pkg::IDX_LAT][2:0]);
  assign sram_wait_cycles_o[1] = lat_cycles(q.cfg[scrb_pkg::IDX_LAT][5:3]);
  assign sram_pipeline_en_o = q.cfg[scrb_pkg::IDX_PIPE][0];
  assign flush_o = q.flush;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  lock_blocks_a: assert property (
    q.wr_pend && q.wr_ofs == scrb_pkg::CFG_OFS[1] && !flash_i.lock[1][0]
    && q.sys_sync[1] && !q.por_pend |=> $stable(cfg_o[1]))
    else $error("Locked register changed on write");
  unlock_write_a: assert property (
    q.wr_pend && q.wr_ofs == scrb_pkg::CFG_OFS[0] && flash_i.lock[0][0]
    && q.sys_sync[1] && !q.por_pend |=> cfg_o[0] == $past(hwdata_i))
    else $error("Unlocked register missed write");
  bit_lock_a: assert property (
    q.wr_pend && q.wr_ofs == scrb_pkg::CFG_OFS[11] && q.sys_sync[1] && !q.por_pend
    |=> ((cfg_o[11] ^ $past(cfg_o[11])) & ~$past(flash_i.lock[11])) == 32'h0)
    else $error("Locked soft-reset bit changed");
  lat_zero_a: assert property (
    q.wr_pend && q.wr_ofs == scrb_pkg::CFG_OFS[0] && flash_i.lock[0][0] && hwdata_i[2:0] == 3'h0
    && q.sys_sync[1] && !q.por_pend |=> sram_wait_cycles_o[0] == 4'h8)
    else $error("Latency code zero not eight cycles");
  base_decode_a: assert property (
    acc && ahb_i.write && !hit |=> !q.wr_pend)
    else $error("Write outside window accepted");
  hidden_read_a: assert property (
    acc && !ahb_i.write && ahb_i.addr == 32'h4003_8128 |=> hrdata_o == 32'h0)
    else $error("Hidden register readable");
  cnt_clear_a: assert property (
    q.wr_pend && q.wr_ofs == scrb_pkg::OFS_CLR && hwdata_i[0] && q.sys_sync[1]
    ##1 evt_i.sec == 2'h0 && evt_i.ded == 2'h0 |=> q.sec_cnt == '0 && q.ded_cnt == '0)
    else $error("Counters not cleared");
  cnt_step_a: assert property (
    evt_i.sec[0] && !q.clr_cnt && q.sys_sync[1] && !q.por_pend
    |=> q.sec_cnt[0] == $past(q.sec_cnt[0]) + 16'h1)
    else $error("Single-bit count not advanced");
  adr_capture_a: assert property (
    (evt_i.sec[1] || evt_i.ded[1]) && q.sys_sync[1] && !q.por_pend
    |=> q.err_adr[1] == $past(evt_i.adr[1]))
    else $error("Error address not captured");
  sticky_hold_a: assert property (
    !q.wr_pend && q.sys_sync[1] |=> (q.sts[1] & $past(q.sts[1])) == $past(q.sts[1]))
    else $error("Sticky bit lost without clear");
  w1c_clear_a: assert property (
    q.wr_pend && q.wr_ofs == scrb_pkg::STS_OFS[2] && evt_i.ext_ev == 32'h0 && q.sys_sync[1]
    |=> (q.sts[2] & $past(hwdata_i)) == 32'h0)
    else $error("Write-one did not clear status");
  por_only_a: assert property (
    !q.sys_sync[1] && q.cc_sync[1] && !q.por_pend && !q.wr_pend |=> $stable(cfg_o[13]))
    else $error("Power-on register hit by system reset");
  cc_reload_a: assert property (
    !q.cc_sync[1] |=> cfg_o[18] == $past(flash_i.init[18]))
    else $error("PLL register not reloaded");
  sys_reload_a: assert property (
    !q.sys_sync[1] |=> cfg_o[0] == $past(flash_i.init[0]) && q.sts == '0)
    else $error("System reset did not reload flash");
  field_lock_a: assert property (
    q.wr_pend && q.wr_ofs == scrb_pkg::CFG_OFS[scrb_pkg::IDX_FACC1]
    && !flash_i.lock[scrb_pkg::IDX_FACC1][1] && q.cc_sync[1] && !q.por_pend
    |=> $stable(cfg_o[scrb_pkg::IDX_FACC1][7:4]))
    else $error("Locked clock field changed");
  field_open_a: assert property (
    q.wr_pend && q.wr_ofs == scrb_pkg::CFG_OFS[scrb_pkg::IDX_FACC1]
    && flash_i.lock[scrb_pkg::IDX_FACC1][0] && q.cc_sync[1] && !q.por_pend
    |=> cfg_o[scrb_pkg::IDX_FACC1][3:0] == $past(hwdata_i[3:0]))
    else $error("Open clock field missed write");
  flush_data_a: assert property (
    q.wr_pend && q.wr_ofs == scrb_pkg::OFS_FLUSH |=> flush_o == $past(hwdata_i))
    else $error("Flush pulse lost data");
  flush_idle_a: assert property (
    !q.wr_pend |=> flush_o == 32'h0)
    else $error("Flush pulse outlived write");
  ecc_gate_a: assert property (
    evt_i.ded[1] && !cfg_o[scrb_pkg::IDX_ECC_EN][3]
    |=> !q.sts[0][3] || $past(q.sts[0][3]))
    else $error("Disabled error status set");
  ecc_set_a: assert property (
    evt_i.sec[0] && cfg_o[scrb_pkg::IDX_ECC_EN][0] && q.sys_sync[1] && !q.por_pend
    |=> q.sts[0][0])
    else $error("Enabled error status not set");
  size_drop_a: assert property (
    acc && ahb_i.write && ahb_i.size != scrb_pkg::SIZE_WORD |=> !q.wr_pend)
    else $error("Sub-word write accepted");
  cause_reset_a: assert property (
    !q.sys_sync[1] |=> reset_cause_o == RCC_RESET)
    else $error("Reset cause not restored");
  prot_keep_a: assert property (
    q.sys_sync[1] && !q.por_pend |=> $stable(fabric_protect_o))
    else $error("Protect window changed by bus");
  shadow_keep_a: assert property (
    !q.por_pend |=> $stable(hidden_o[scrb_pkg::HID_POR_IDX]))
    else $error("Code-shadow status reloaded");
  hid_load_a: assert property (
    !q.sys_sync[1] |=> hidden_o[0] == $past(flash_i.hid[0]))
    else $error("Security register not loaded");
  window_read_a: assert property (
    acc && !ahb_i.write && !hit |=> hrdata_o == 32'h0)
    else $error("Read outside window answered");
  reserved_read_a: assert property (
    acc && !ahb_i.write && ahb_i.addr == scrb_pkg::BASE_ADDR + 32'h8 |=> hrdata_o == 32'h0)
    else $error("Reserved offset read nonzero");
  cc_keep_a: assert property (
    q.cc_sync[1] && !q.sys_sync[1] && !q.por_pend && !q.wr_pend
    |=> $stable(cfg_o[scrb_pkg::IDX_PLL_LO]))
    else $error("PLL register hit by system reset");

endmodule // scrb_bank

//--- rtl/scrb_pkg.sv
// System register bank constants and carrier types
package scrb_pkg;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] BASE_ADDR = 32'h4003_8000;
  localparam int WIN_LSB = 12;
  localparam int NCFG = 24;
  localparam int NRO = 10;
  localparam int NHID = 5;
  localparam int NSTS = 3;
  localparam int HID_POR_IDX = 4;
  localparam int FIELD_W = 4;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [NCFG-1:0][11:0] CFG_OFS = {12'h0A8, 12'h0A4, 12'h09C, 12'h098,
    12'h094, 12'h090, 12'h080, 12'h078, 12'h070, 12'h068, 12'h060, 12'h050, 12'h048,
    12'h044, 12'h040, 12'h03C, 12'h038, 12'h034, 12'h030, 12'h02C, 12'h028, 12'h014,
    12'h00C, 12'h004};
  localparam logic [NCFG-1:0] CFG_POR = 24'h00_E000;
  localparam logic [NCFG-1:0] CFG_CC = 24'h3C_0000;
  localparam int IDX_LAT = 0;
  localparam int IDX_SRST = 11;
  localparam int IDX_DDR = 13;
  localparam int IDX_ECC_EN = 16;
  localparam int IDX_PIPE = 17;
  localparam int IDX_PLL_LO = 18;
  localparam int IDX_FACC1 = 20;
  localparam int IDX_FACC2 = 21;
  localparam logic [NRO-1:0][11:0] RO_OFS = {12'h168, 12'h164, 12'h160, 12'h158, 12'h150,
    12'h140, 12'h0EC, 12'h0E8, 12'h0E4, 12'h0E0};
  localparam logic [NHID-1:0][11:0] HID_OFS = {12'h148, 12'h144, 12'h130, 12'h12C, 12'h128};
  localparam logic [NSTS-1:0][11:0] STS_OFS = {12'h198, 12'h194, 12'h190};
  localparam logic [11:0] OFS_RCC = 12'h0B0;
  localparam logic [11:0] OFS_CNT0 = 12'h0F0;
  localparam logic [11:0] OFS_CNT1 = 12'h0F4;
  localparam logic [11:0] OFS_ADR0 = 12'h10C;
  localparam logic [11:0] OFS_ADR1 = 12'h110;
  localparam logic [11:0] OFS_VER = 12'h14C;
  localparam logic [11:0] OFS_PSIZE = 12'h184;
  localparam logic [11:0] OFS_PBASE = 12'h188;
  localparam logic [11:0] OFS_CLR = 12'h1A4;
  localparam logic [11:0] OFS_FLUSH = 12'h1A8;
  localparam logic [31:0] RCC_RST_DEF = 32'h0000_0000;
  localparam logic [3:0] LAT_ZERO_CYC = 4'h8;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic [31:0] addr;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic ready;
  } scrb_ahb_req_t;

  typedef struct packed {
    logic [NCFG-1:0][31:0] init;
    logic [NCFG-1:0][31:0] lock;
    logic [1:0][31:0] prot;
    logic [NHID-1:0][31:0] hid;
  } scrb_flash_t;

  typedef struct packed {
    logic [1:0] sec;
    logic [1:0] ded;
    logic [1:0][31:0] adr;
    logic [31:0] int_ev;
    logic [31:0] ext_ev;
  } scrb_evt_t;

  typedef struct packed {
    logic [NCFG-1:0][31:0] cfg;
    logic [31:0] rst_cause;
    logic [1:0][31:0] prot;
    logic [NHID-1:0][31:0] hid;
    logic [1:0][15:0] sec_cnt;
    logic [1:0][15:0] ded_cnt;
    logic [1:0][31:0] err_adr;
    logic [NSTS-1:0][31:0] sts;
    logic [31:0] flush;
    logic clr_cnt;
    logic por_pend;
    logic [1:0] sys_sync;
    logic [1:0] cc_sync;
    logic wr_pend;
    logic [11:0] wr_ofs;
    logic [31:0] rdata;
  } scrb_state_t;
endpackage
